/* File: hw/sentence_framer.sv */
// Field reading sentence framer with character FIFO and 8N1 serial transmitter
`timescale 1ns/1ns

// ********************
// Character FIFO
// ********************
module char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("char_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	assign in_ready = count != CW'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) wr_ptr <= wr_ptr + AW'(1);
			if (do_pop) rd_ptr <= rd_ptr + AW'(1);
			if (do_push && !do_pop) count <= count + CW'(1);
			else if (do_pop && !do_push) count <= count - CW'(1);
		end
	end
endmodule : char_fifo

// ********************
// Sentence framer
// ********************
// How it works
// - A new sentence starts on each of twenty evenly spaced ticks per second.
// - Every character leaves as one start bit, eight data bits, one stop bit, 9600 baud.
// - Sentence opens with a dollar sign, then plus or minus for field polarity.
// - Magnitude follows as two digits, a point, two digits, from 00.00 to 20.00.
// - Field is taken in hundredths of kV/m and clamped to plus or minus twenty.
// - A comma then one fault digit: zero normal, one rotor fault.
// - Rotor pulse spacing is watched all the time; outside the window flags a fault.
// - An asterisk then the checksum as two upper-case hex characters.
// - Every sentence ends with carriage return immediately followed by line feed.
module sentence_framer
	import framer_pkg::*;
#(
	parameter int TICK_PERIOD = TICK_CYCLES,
	parameter int BIT_PERIOD = BIT_CYCLES,
	parameter int ROTOR_MIN = ROTOR_MIN_CYCLES,
	parameter int ROTOR_MAX = ROTOR_MAX_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic signed [15:0] field_value,
	input wire logic rotor_pulse,
	output logic serial_out,
	output logic rotor_fault
);
	typedef enum logic {build_idle, build_send} build_e;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	generate
		if (TICK_PERIOD < 2 || BIT_PERIOD < 2 || ROTOR_MIN >= ROTOR_MAX) begin : g_bad_param
			$error("sentence_framer: bad timing parameters");
		end
	endgenerate

	// ********************
	// Sentence tick
	// ********************
	logic [31:0] tick_cnt;
	wire tick = tick_cnt == 32'(TICK_PERIOD - 1);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) tick_cnt <= '0;
		else tick_cnt <= tick ? '0 : tick_cnt + 32'd1;
	end

	// ********************
	// Rotor monitor
	// ********************
	logic rot_s1;
	logic rot_s2;
	logic rot_s3;
	logic [31:0] rot_cnt;
	wire rot_edge = rot_s2 && !rot_s3;
	wire rot_over = rot_cnt > 32'(ROTOR_MAX);
	wire rot_under = rot_cnt < 32'(ROTOR_MIN);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rot_s1 <= 1'b0;
			rot_s2 <= 1'b0;
			rot_s3 <= 1'b0;
			rot_cnt <= '0;
			rotor_fault <= 1'b0;
		end else begin
			rot_s1 <= rotor_pulse;
			rot_s2 <= rot_s1;
			rot_s3 <= rot_s2;
			// A stalled rotor gives no edges, so overflow alone must raise the fault
			if (rot_edge) begin
				rot_cnt <= '0;
				rotor_fault <= rot_under || rot_over;
			end else if (rot_over) begin
				rotor_fault <= 1'b1;
			end else begin
				rot_cnt <= rot_cnt + 32'd1;
			end
		end
	end

	// ********************
	// Sentence builder
	// ********************
	build_e state;
	build_e next_state;
	logic [3:0] idx;
	logic neg;
	logic fault_snap;
	logic [11:0] mag;
	logic [7:0] csum;
	logic [7:0] push_data;
	logic push_ready;
	wire push_valid = state == build_send;
	wire push_fire = push_valid && push_ready;
	wire in_neg = field_value[15];
	wire [15:0] abs_val = in_neg ? 16'(-field_value) : 16'(field_value);
	wire [11:0] clamped = (abs_val > {4'h0, FIELD_LIMIT}) ? FIELD_LIMIT : abs_val[11:0];
	wire [3:0] d_tens = 4'(mag / 12'd1000);
	wire [3:0] d_ones = 4'((mag / 12'd100) % 12'd10);
	wire [3:0] d_tenths = 4'((mag / 12'd10) % 12'd10);
	wire [3:0] d_hunds = 4'(mag % 12'd10);
	wire csum_span = idx >= IDX_SIGN && idx <= IDX_FAULT;

	always_comb begin
		unique case (idx)
			IDX_DOLLAR: push_data = CH_DOLLAR;
			IDX_SIGN: push_data = neg ? CH_MINUS : CH_PLUS;
			IDX_TENS: push_data = hex_char(d_tens);
			IDX_ONES: push_data = hex_char(d_ones);
			IDX_DOT: push_data = CH_DOT;
			IDX_TENTHS: push_data = hex_char(d_tenths);
			IDX_HUNDS: push_data = hex_char(d_hunds);
			IDX_COMMA: push_data = CH_COMMA;
			IDX_FAULT: push_data = fault_snap ? CH_ONE : CH_ZERO;
			IDX_STAR: push_data = CH_STAR;
			IDX_CS_HI: push_data = hex_char(csum[7:4]);
			IDX_CS_LO: push_data = hex_char(csum[3:0]);
			IDX_CR: push_data = CH_CR;
			IDX_LF: push_data = CH_LF;
			default: push_data = CH_LF;
		endcase
	end

	assign next_state = (state == build_idle && tick) ? build_send :
		(push_fire && idx == IDX_LF) ? build_idle : state;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= build_idle;
			idx <= IDX_DOLLAR;
			neg <= 1'b0;
			fault_snap <= 1'b0;
			mag <= '0;
			csum <= '0;
		end else begin
			state <= next_state;
			// Fields are frozen at the tick so a sentence never mixes two readings
			if (state == build_idle && tick) begin
				idx <= IDX_DOLLAR;
				neg <= in_neg && clamped != '0;
				mag <= clamped;
				fault_snap <= rotor_fault;
				csum <= '0;
			end else if (push_fire) begin
				idx <= (idx == IDX_LF) ? IDX_DOLLAR : idx + 4'h1;
				if (csum_span) csum <= csum_step(csum, push_data);
			end
		end
	end

	// ********************
	// FIFO and serial transmitter
	// ********************
	logic tx_busy;
	logic [31:0] baud_cnt;
	logic [3:0] bit_idx;
	logic [FRAME_BITS-1:0] shift;
	logic fifo_valid;
	logic [7:0] fifo_data;
	wire tx_load = fifo_valid && !tx_busy;
	wire baud_end = baud_cnt == 32'(BIT_PERIOD - 1);
	wire last_bit = bit_idx == 4'(FRAME_BITS - 1);

	char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(fifo_valid),
		.out_ready(!tx_busy),
		.out_data(fifo_data)
	);

	assign serial_out = shift[0];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_busy <= 1'b0;
			baud_cnt <= '0;
			bit_idx <= '0;
			shift <= '1;
		end else if (tx_load) begin
			tx_busy <= 1'b1;
			baud_cnt <= '0;
			bit_idx <= '0;
			shift <= {{STOP_BITS{1'b1}}, fifo_data, 1'b0};
		end else if (tx_busy) begin
			baud_cnt <= baud_end ? '0 : baud_cnt + 32'd1;
			if (baud_end) begin
				shift <= {1'b1, shift[FRAME_BITS-1:1]};
				bit_idx <= bit_idx + 4'h1;
				if (last_bit) tx_busy <= 1'b0;
			end
		end
	end

	// ********************
	// Checks
	// ********************
	sequence s_cr_push;
		push_fire && idx == IDX_CR && push_data == CH_CR;
	endsequence
	sequence s_lf_next;
		##1 state == build_send && idx == IDX_LF && push_data == CH_LF;
	endsequence
	sequence s_start_bit;
		$rose(tx_busy) && !serial_out;
	endsequence

	property p_tick_start;
		(state == build_idle && tick) |=> state == build_send && idx == IDX_DOLLAR;
	endproperty
	a_tick_start: assert property (p_tick_start) else $error("tick did not start a sentence");

	property p_frame;
		$rose(tx_busy) |-> s_start_bit ##1 (!serial_out && bit_idx == 4'h0);
	endproperty
	a_frame: assert property (p_frame) else $error("start bit missing");

	property p_stop_bit;
		(tx_busy && last_bit) |-> serial_out;
	endproperty
	a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high");

	property p_sign;
		(push_fire && idx == IDX_SIGN) |-> push_data == ((neg && mag != '0) ? CH_MINUS : CH_PLUS);
	endproperty
	a_sign: assert property (p_sign) else $error("bad sign character");

	property p_dot;
		(push_fire && idx == IDX_DOT) |-> push_data == CH_DOT && d_tens <= 4'h2;
	endproperty
	a_dot: assert property (p_dot) else $error("bad magnitude layout");

	property p_clamp;
		state == build_send |-> mag <= FIELD_LIMIT;
	endproperty
	a_clamp: assert property (p_clamp) else $error("magnitude above limit");

	property p_fault_char;
		(push_fire && idx == IDX_FAULT) |-> push_data == (fault_snap ? CH_ONE : CH_ZERO);
	endproperty
	a_fault_char: assert property (p_fault_char) else $error("bad fault digit");

	property p_fault_snap;
		(state == build_idle && tick) |=> fault_snap == $past(rotor_fault);
	endproperty
	a_fault_snap: assert property (p_fault_snap) else $error("fault snapshot wrong");

	property p_rotor;
		(rot_edge && (rot_under || rot_over)) |=> rotor_fault;
	endproperty
	a_rotor: assert property (p_rotor) else $error("rotor fault not raised");

	property p_checksum;
		(push_fire && idx == IDX_STAR) |=> idx == IDX_CS_HI && push_data == hex_char(csum[7:4]);
	endproperty
	a_checksum: assert property (p_checksum) else $error("checksum high nibble wrong");

	property p_crlf;
		s_cr_push |-> s_lf_next;
	endproperty
	a_crlf: assert property (p_crlf) else $error("CR not followed by LF");

	property p_csum_hold;
		(state == build_send && idx > IDX_FAULT) |=> $stable(csum);
	endproperty
	a_csum_hold: assert property (p_csum_hold) else $error("checksum changed late");
endmodule : sentence_framer

/* File: pkg/framer_pkg.sv */
// Constants, character codes and helper functions for the field reading sentence framer
package framer_pkg;
	// ********************
	// Timing
	// ********************
	localparam int CLK_HZ = 125_000_000;
	localparam int SENTENCE_HZ = 20;
	localparam int BAUD = 9600;
	localparam int TICK_CYCLES = CLK_HZ / SENTENCE_HZ;
	// Rounded down: 13020 cycles, 0.006 % fast, well inside UART tolerance
	localparam int BIT_CYCLES = CLK_HZ / BAUD;
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 1;
	localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
	// Rotor pulse spacing window, plain defaults
	localparam int ROTOR_MIN_CYCLES = 1_000_000;
	localparam int ROTOR_MAX_CYCLES = 1_500_000;
	// ********************
	// Sentence layout
	// ********************
	localparam logic [11:0] FIELD_LIMIT = 12'h7d0;
	localparam logic [3:0] IDX_DOLLAR = 4'h0;
	localparam logic [3:0] IDX_SIGN = 4'h1;
	localparam logic [3:0] IDX_TENS = 4'h2;
	localparam logic [3:0] IDX_ONES = 4'h3;
	localparam logic [3:0] IDX_DOT = 4'h4;
	localparam logic [3:0] IDX_TENTHS = 4'h5;
	localparam logic [3:0] IDX_HUNDS = 4'h6;
	localparam logic [3:0] IDX_COMMA = 4'h7;
	localparam logic [3:0] IDX_FAULT = 4'h8;
	localparam logic [3:0] IDX_STAR = 4'h9;
	localparam logic [3:0] IDX_CS_HI = 4'ha;
	localparam logic [3:0] IDX_CS_LO = 4'hb;
	localparam logic [3:0] IDX_CR = 4'hc;
	localparam logic [3:0] IDX_LF = 4'hd;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_ALPHA = 8'h37;
	localparam logic [3:0] NINE = 4'h9;

	// Upper-case hex digit
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n > NINE) ? (CH_ALPHA + {4'h0, n}) : (CH_ZERO + {4'h0, n});
	endfunction : hex_char

	// Checksum step; swap this when the real algorithm is confirmed on captured traffic
	function automatic logic [7:0] csum_step(input logic [7:0] acc, input logic [7:0] ch);
		csum_step = acc ^ ch;
	endfunction : csum_step
endpackage : framer_pkg

/* File: bench/host_serial_rx.sv */
// Host side serial receiver model that turns the framer's line back into characters
`timescale 1ns/1ns

module host_serial_rx #(
	parameter int BIT_PERIOD = 4,
	parameter int LOST_CYCLES = 2100
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic serial_line,
	output logic char_valid,
	output logic [7:0] char_data,
	output logic frame_err,
	output logic signal_lost
);
	logic [7:0] shreg;
	int quiet = 0;

	// ********************
	// Frame receiver
	// ********************
	// Sampled on the falling edge so the line is never read in the edge that moves it
	initial begin
		char_valid = 1'b0;
		frame_err = 1'b0;
		char_data = 8'h00;
		shreg = 8'h00;
		forever begin
			@(negedge clk);
			char_valid <= 1'b0;
			if (reset_n && !serial_line) begin
				repeat (BIT_PERIOD / 2) @(negedge clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_PERIOD) @(negedge clk);
					shreg[i] = serial_line;
				end
				repeat (BIT_PERIOD) @(negedge clk);
				char_data <= shreg;
				frame_err <= !serial_line;
				char_valid <= 1'b1;
			end
		end
	end

	// ********************
	// Signal loss watch
	// ********************
	// Checksum is left unchecked here; the bench judges it on its own
	always @(negedge clk) begin
		if (char_valid)
			quiet <= 0;
		else if (quiet <= LOST_CYCLES)
			quiet <= quiet + 1;
	end
	assign signal_lost = (quiet > LOST_CYCLES);
endmodule : host_serial_rx

/* File: bench/tb_sentence_framer.sv */
// Self-checking testbench for the field reading sentence framer
`timescale 1ns/1ns

module tb_sentence_framer;
	import framer_pkg::*;
	localparam int TICK = 700;
	localparam int BITP = 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic signed [15:0] field_value = 16'h0000;
	logic rotor_pulse = 1'b0;
	logic serial_out, rotor_fault, char_valid, frame_err, signal_lost;
	logic [7:0] char_data;
	logic [7:0] rx_q[$];
	int rx_t[$];
	int bad_count = 0;
	int n_compared = 0;
	int rotor_gap = 30;
	int cyc = 0;

	sentence_framer #(.TICK_PERIOD(TICK), .BIT_PERIOD(BITP), .ROTOR_MIN(20), .ROTOR_MAX(40),
		.FIFO_DEPTH(8)) sentence_framer_inst (.clk(clk), .reset_n(reset_n),
		.field_value(field_value), .rotor_pulse(rotor_pulse), .serial_out(serial_out),
		.rotor_fault(rotor_fault));
	host_serial_rx #(.BIT_PERIOD(BITP), .LOST_CYCLES(3 * TICK)) host_serial_rx_inst (
		.clk(clk), .reset_n(reset_n), .serial_line(serial_out), .char_valid(char_valid),
		.char_data(char_data), .frame_err(frame_err), .signal_lost(signal_lost));

	// ********************
	// Clock, rotor and capture
	// ********************
	initial begin
		forever #4 clk = ~clk;
	end

	// A gap of zero stalls the rotor
	initial begin
		forever begin
			if (rotor_gap == 0) begin
				@(posedge clk);
			end else begin
				@(posedge clk);
				#1 rotor_pulse = 1'b1;
				repeat (2) @(posedge clk);
				#1 rotor_pulse = 1'b0;
				repeat (rotor_gap - 3) @(posedge clk);
			end
		end
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (char_valid) begin
			rx_q.push_back(char_data);
			rx_t.push_back(cyc);
			check_val(32'(frame_err), 32'h0, "stop bit level");
		end
	end

	// ********************
	// Shared tasks
	// ********************
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : check_val

	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction : hexc

	task automatic next_char(output logic [7:0] c, output int t);
		int n = 0;
		while (rx_q.size() == 0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		c = 8'h00;
		t = 0;
		if (rx_q.size() == 0)
			check_val(32'h0, 32'h1, "no character arrived");
		else begin
			c = rx_q.pop_front();
			t = rx_t.pop_front();
		end
	endtask : next_char

	task automatic wait_dollar(output int t);
		logic [7:0] c = 8'h00;
		int k = 0;
		t = 0;
		while (c !== CH_DOLLAR && k < 40) begin
			next_char(c, t);
			k++;
		end
	endtask : wait_dollar

	// Inputs change just after the dollar sign of one sentence has been captured, the next one is judged
	task automatic run_case(input int v, input int gap, input logic flt);
		logic [7:0] exp [14];
		logic [7:0] c;
		logic [7:0] cs;
		int m, t0, t1;
		wait_dollar(t0);
		@(posedge clk);
		#1 field_value = 16'(v);
		rotor_gap = gap;
		repeat (13) next_char(c, t1);
		wait_dollar(t1);
		check_val(32'(t1 - t0), 32'(TICK), "sentence spacing");
		m = (v < 0) ? -v : v;
		if (m > 2000)
			m = 2000;
		exp = '{CH_DOLLAR, (v < 0 && m != 0) ? CH_MINUS : CH_PLUS, 8'h30 + 8'(m / 1000),
			8'h30 + 8'(m / 100 % 10), CH_DOT, 8'h30 + 8'(m / 10 % 10), 8'h30 + 8'(m % 10),
			CH_COMMA, flt ? CH_ONE : CH_ZERO, CH_STAR, 8'h00, 8'h00, CH_CR, CH_LF};
		cs = 8'h00;
		for (int i = 1; i < 9; i++)
			cs ^= exp[i];
		exp[10] = hexc(cs[7:4]);
		exp[11] = hexc(cs[3:0]);
		for (int i = 1; i < 14; i++) begin
			next_char(c, t1);
			check_val(32'(c), 32'(exp[i]), "sentence character");
		end
		check_val(32'(rotor_fault), 32'(flt), "rotor fault output");
	endtask : run_case

	// ********************
	// Scenarios
	// ********************
	task automatic test_plain;
		run_case(33, 30, 1'b0);
		$display("test_plain done");
	endtask : test_plain

	// Boundaries of the clamp, both signs, and zero which must carry a plus
	task automatic test_field_range;
		int vals[9] = '{-32768, -2001, -2000, -5, 0, 1999, 2000, 2001, 32767};
		foreach (vals[i])
			run_case(vals[i], 30, 1'b0);
		$display("test_field_range done");
	endtask : test_field_range

	task automatic test_rotor;
		int gaps[5] = '{60, 10, 30, 0, 30};
		bit flts[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		foreach (gaps[i])
			run_case(gaps[i], gaps[i], flts[i]);
		$display("test_rotor done");
	endtask : test_rotor

	// Reset lands between sentences so no frame is cut
	task automatic test_signal_lost;
		logic [7:0] c;
		int t;
		wait_dollar(t);
		repeat (13) next_char(c, t);
		@(posedge clk);
		#1 reset_n = 1'b0;
		repeat (2300) @(posedge clk);
		check_val(32'(serial_out), 32'h1, "line idle in reset");
		check_val(32'(signal_lost), 32'h1, "signal lost raised");
		#1 reset_n = 1'b1;
		run_case(-1234, 30, 1'b0);
		check_val(32'(signal_lost), 32'h0, "signal lost cleared");
		$display("test_signal_lost done");
	endtask : test_signal_lost

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	initial begin
		repeat (8) @(posedge clk);
		#1 reset_n = 1'b1;
		test_plain;
		test_field_range;
		test_rotor;
		test_signal_lost;
		stop_test;
	end

	// About 26500 cycles are needed; the limit leaves ample room
	initial begin
		#(60000 * 8);
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		stop_test;
	end
endmodule : tb_sentence_framer
